// file: design/csfb_pkg.sv
/*
  csfb_pkg: constants and types of the cpu status, flag and bank block.
  assumes a single 20 MHz core clock and a 32-bit wishbone register bus.
*/
package csfb_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] OFS_PC   = 8'h00;
  localparam logic [7:0] OFS_ACC  = 8'h04;
  localparam logic [7:0] OFS_TMP  = 8'h08;
  localparam logic [7:0] OFS_IX   = 8'h0C;
  localparam logic [7:0] OFS_EP   = 8'h10;
  localparam logic [7:0] OFS_SP   = 8'h14;
  localparam logic [7:0] OFS_PSW  = 8'h18;
  localparam logic [7:0] OFS_BANK = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;

  // condition code byte fields
  localparam int CC_C   = 0;
  localparam int CC_V   = 1;
  localparam int CC_Z   = 2;
  localparam int CC_N   = 3;
  localparam int CC_IL0 = 4;
  localparam int CC_IL1 = 5;
  localparam int CC_I   = 6;
  localparam int CC_H   = 7;

  // reset values
  localparam logic [15:0] RST_PC  = 16'h0000;
  localparam logic [15:0] RST_SP  = 16'h0000;
  localparam logic [7:0]  RST_RP  = 8'h00;
  localparam logic [7:0]  RST_CCR = 8'h30;

  // address space layout, 64 Kbytes
  localparam logic [15:0] IO_LAST    = 16'h007F;
  localparam logic [15:0] DATA_LAST  = 16'h07FF;
  localparam logic [15:0] PROG_FIRST = 16'h8000;
  localparam logic [15:0] BANK_BASE  = 16'h0100;
  localparam logic [2:0]  BANK_SHIFT = 3'h3;
  localparam logic [4:0]  BANK_LAST  = 5'h1F;

  // interrupt level that is never admitted; as mask it admits levels 0 to 2
  localparam logic [1:0] IL_NONE = 2'h3;

  typedef enum logic [3:0] {
    OP_NOP  = 4'h0,
    OP_LDA  = 4'h1,
    OP_LDT  = 4'h2,
    OP_ADD  = 4'h3,
    OP_ADDC = 4'h4,
    OP_SUB  = 4'h5,
    OP_SUBC = 4'h6,
    OP_SHL  = 4'h7,
    OP_SHR  = 4'h8,
    OP_LDPC = 4'h9,
    OP_INPC = 4'hA,
    OP_SETI = 4'hB,
    OP_CLRI = 4'hC,
    OP_LDIL = 4'hD,
    OP_LDRP = 4'hE
  } csfb_op_t;

  typedef enum logic [1:0] {
    REG_IO   = 2'h0,
    REG_DATA = 2'h1,
    REG_GAP  = 2'h3,
    REG_PROG = 2'h2
  } csfb_region_t;

  typedef struct packed {
    logic        valid;
    csfb_op_t    op;
    logic        wide;
    logic [15:0] data;
  } csfb_cmd_t;

  typedef struct packed {
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } csfb_flags_t;

endpackage

// file: design/csfb_adder.sv
/*
  csfb_adder: add or subtract with carry and the arithmetic flags.
  assumes the caller picks 8- or 16-bit width; combinational only.
*/
`timescale 1ns/1ps
module csfb_adder (
  // operands
  input  wire logic [15:0]         a,
  input  wire logic [15:0]         b,
  input  wire logic                cin,
  input  wire logic                sub,
  input  wire logic                wide,
  // result
  output logic [15:0]              res,
  output csfb_pkg::csfb_flags_t    flg
);

  wire logic [15:0] opb   = sub ? ~b : b;
  wire logic        cyin  = sub ? ~cin : cin;
  wire logic [16:0] sum   = {1'b0, a} + {1'b0, opb} + {16'h0000, cyin};
  wire logic [4:0]  nib   = {1'b0, a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cyin};
  wire logic [8:0]  lo    = {1'b0, a[7:0]} + {1'b0, opb[7:0]} + {8'h00, cyin};
  wire logic        cout  = wide ? sum[16] : lo[8];
  wire logic        msb_a = wide ? a[15] : a[7];
  wire logic        msb_b = wide ? opb[15] : opb[7];
  wire logic        msb_r = wide ? sum[15] : lo[7];

  assign res   = wide ? sum[15:0] : {a[15:8], lo[7:0]};
  assign flg.h = nib[4] ^ sub;
  assign flg.c = cout ^ sub;
  assign flg.n = msb_r;
  assign flg.z = wide ? (sum[15:0] == 16'h0000) : (lo[7:0] == 8'h00);
  assign flg.v = (msb_a == msb_b) && (msb_r != msb_a);

endmodule // csfb_adder

// file: design/csfb_core.sv
/*
  csfb_core: dedicated cpu registers, program status word, flag update,
  interrupt gate, register bank addressing and address region decode.
  assumes the instruction sequencer runs on sys_clk and issues at most
  one command a cycle; software reaches the registers over wishbone.
*/
`timescale 1ns/1ps

module csfb_core (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o,
  // instruction sequencer
  input  wire csfb_pkg::csfb_cmd_t     seq_cmd,
  input  wire logic [2:0]              seq_reg_idx,
  input  wire logic [15:0]             seq_mem_addr,
  // interrupt request
  input  wire logic                    irq_req,
  input  wire logic [1:0]              irq_level,
  output logic                         irq_take_ff,
  // state toward the core
  output logic [15:0]                  program_counter_ff,
  output logic [15:0]                  acc_ff,
  output logic [15:0]                  index_register_ff,
  output logic [15:0]                  extra_pointer_ff,
  output logic [15:0]                  stack_pointer_ff,
  output logic [15:0]                  program_status_word_ff,
  output logic [15:0]                  gpr_addr_ff,
  output csfb_pkg::csfb_region_t       region_ff
);

  logic [15:0] tmp_ff;
  logic [7:0]  bank_select_pointer_ff;
  logic [7:0]  condition_code_byte_ff;

  // bus decode
  wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic bus_wr  = bus_req && wb_we_i;
  wire logic lane0   = wb_sel_i[0];
  wire logic lane1   = wb_sel_i[1];
  wire logic wr_pc   = bus_wr && (wb_adr_i == csfb_pkg::OFS_PC);
  wire logic wr_acc  = bus_wr && (wb_adr_i == csfb_pkg::OFS_ACC);
  wire logic wr_tmp  = bus_wr && (wb_adr_i == csfb_pkg::OFS_TMP);
  wire logic wr_ix   = bus_wr && (wb_adr_i == csfb_pkg::OFS_IX);
  wire logic wr_ep   = bus_wr && (wb_adr_i == csfb_pkg::OFS_EP);
  wire logic wr_sp   = bus_wr && (wb_adr_i == csfb_pkg::OFS_SP);
  wire logic wr_psw  = bus_wr && (wb_adr_i == csfb_pkg::OFS_PSW);

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic        l0,
                                          input logic        l1);
    merge16 = {l1 ? new_v[15:8] : old_v[15:8], l0 ? new_v[7:0] : old_v[7:0]};
  endfunction

  // sequencer decode
  wire logic      cmd_v  = seq_cmd.valid;
  wire csfb_pkg::csfb_op_t op = seq_cmd.op;
  wire logic      is_add = cmd_v && (op == csfb_pkg::OP_ADD || op == csfb_pkg::OP_ADDC);
  wire logic      is_sub = cmd_v && (op == csfb_pkg::OP_SUB || op == csfb_pkg::OP_SUBC);
  wire logic      use_c  = (op == csfb_pkg::OP_ADDC) || (op == csfb_pkg::OP_SUBC);
  wire logic      is_shl = cmd_v && (op == csfb_pkg::OP_SHL);
  wire logic      is_shr = cmd_v && (op == csfb_pkg::OP_SHR);
  wire logic      is_ari = is_add || is_sub;
  wire logic      is_sh  = is_shl || is_shr;
  wire logic      c_old  = condition_code_byte_ff[csfb_pkg::CC_C];

  // arithmetic against the temporary accumulator
  logic [15:0]           add_res;
  csfb_pkg::csfb_flags_t add_flg;

  csfb_adder u_adder (
    .a    (acc_ff),
    .b    (tmp_ff),
    .cin  (use_c ? c_old : 1'b0),
    .sub  (is_sub),
    .wide (seq_cmd.wide),
    .res  (add_res),
    .flg  (add_flg)
  );

  // shifts, byte or word wide
  wire logic        sh_wide = seq_cmd.wide;
  wire logic        sh_out  = is_shl ? (sh_wide ? acc_ff[15] : acc_ff[7]) : acc_ff[0];
  wire logic [15:0] shl_w   = {acc_ff[14:0], 1'b0};
  wire logic [15:0] shr_w   = {1'b0, acc_ff[15:1]};
  wire logic [15:0] shl_b   = {acc_ff[15:8], acc_ff[6:0], 1'b0};
  wire logic [15:0] shr_b   = {acc_ff[15:8], 1'b0, acc_ff[7:1]};
  wire logic [15:0] sh_res  = is_shl ? (sh_wide ? shl_w : shl_b)
                                     : (sh_wide ? shr_w : shr_b);
  wire logic        sh_n    = sh_wide ? sh_res[15] : sh_res[7];
  wire logic        sh_z    = sh_wide ? (sh_res == 16'h0000) : (sh_res[7:0] == 8'h00);

  // accumulator next value
  wire logic [15:0] acc_seq = is_ari ? add_res
                            : is_sh  ? sh_res
                            : (cmd_v && op == csfb_pkg::OP_LDA) ? seq_cmd.data
                            : acc_ff;
  wire logic [15:0] nxt_acc = wr_acc ? merge16(acc_ff, wb_dat_i[15:0], lane0, lane1) : acc_seq;

  wire logic [15:0] tmp_seq = (cmd_v && op == csfb_pkg::OP_LDT) ? seq_cmd.data : tmp_ff;
  wire logic [15:0] nxt_tmp = wr_tmp ? merge16(tmp_ff, wb_dat_i[15:0], lane0, lane1) : tmp_seq;

  // program counter
  // relative step wraps inside the 64K space
  wire logic [16:0] pc_sum = {1'b0, program_counter_ff} + {1'b0, seq_cmd.data};
  wire logic [15:0] pc_seq = (cmd_v && op == csfb_pkg::OP_LDPC) ? seq_cmd.data
                           : (cmd_v && op == csfb_pkg::OP_INPC)
                             ? pc_sum[15:0]
                             : program_counter_ff;
  wire logic [15:0] nxt_pc = wr_pc
                           ? merge16(program_counter_ff, wb_dat_i[15:0], lane0, lane1)
                           : pc_seq;

  // condition code byte: flags
  logic [7:0] ccr_seq;
  always_comb
  begin
    ccr_seq = condition_code_byte_ff;
    if (is_ari)
    begin
      ccr_seq[csfb_pkg::CC_H] = add_flg.h;
      ccr_seq[csfb_pkg::CC_N] = add_flg.n;
      ccr_seq[csfb_pkg::CC_Z] = add_flg.z;
      ccr_seq[csfb_pkg::CC_V] = add_flg.v;
      ccr_seq[csfb_pkg::CC_C] = add_flg.c;
    end
    else if (is_sh)
    begin
      ccr_seq[csfb_pkg::CC_N] = sh_n;
      ccr_seq[csfb_pkg::CC_Z] = sh_z;
      ccr_seq[csfb_pkg::CC_C] = sh_out;
    end
    else if (cmd_v && op == csfb_pkg::OP_SETI)
      ccr_seq[csfb_pkg::CC_I] = 1'b1;
    else if (cmd_v && op == csfb_pkg::OP_CLRI)
      ccr_seq[csfb_pkg::CC_I] = 1'b0;
    else if (cmd_v && op == csfb_pkg::OP_LDIL)
    begin
      ccr_seq[csfb_pkg::CC_IL1] = seq_cmd.data[1];
      ccr_seq[csfb_pkg::CC_IL0] = seq_cmd.data[0];
    end
  end

  // interrupt gate: lower code is higher level
  wire logic [1:0] mask_lvl = {condition_code_byte_ff[csfb_pkg::CC_IL1],
                               condition_code_byte_ff[csfb_pkg::CC_IL0]};
  wire logic       lvl_ok   = (irq_level < mask_lvl)
                           && (irq_level != csfb_pkg::IL_NONE);
  wire logic       irq_ok   = irq_req && condition_code_byte_ff[csfb_pkg::CC_I]
                           && lvl_ok && !irq_take_ff;
  // taking an interrupt blocks further ones until software re-enables
  wire logic [7:0] ccr_irq  = irq_ok ? (ccr_seq & ~(8'h01 << csfb_pkg::CC_I)) : ccr_seq;
  wire logic [7:0] nxt_ccr  = (wr_psw && lane0) ? wb_dat_i[7:0] : ccr_irq;

  // bank pointer, high byte of the status word
  wire logic [7:0] rp_seq = (cmd_v && op == csfb_pkg::OP_LDRP)
                          ? seq_cmd.data[7:0] : bank_select_pointer_ff;
  wire logic [7:0] nxt_rp = (wr_psw && lane1) ? wb_dat_i[15:8] : rp_seq;

  // bank base and register address
  wire logic [4:0]  bank_no   = bank_select_pointer_ff[4:0];
  wire logic [15:0] bank_ofs  = {11'h000, bank_no} << csfb_pkg::BANK_SHIFT;
  wire logic [15:0] bank_addr = csfb_pkg::BANK_BASE + bank_ofs;
  wire logic [15:0] nxt_gpr   = bank_addr + {13'h0000, seq_reg_idx};

  // address region decode
  wire csfb_pkg::csfb_region_t nxt_region =
      (seq_mem_addr <= csfb_pkg::IO_LAST)    ? csfb_pkg::REG_IO
    : (seq_mem_addr <= csfb_pkg::DATA_LAST)  ? csfb_pkg::REG_DATA
    : (seq_mem_addr >= csfb_pkg::PROG_FIRST) ? csfb_pkg::REG_PROG
    : csfb_pkg::REG_GAP;

  // read mux
  wire logic [31:0] stat_word = {28'h0000_000, 1'b0, irq_take_ff, mask_lvl == csfb_pkg::IL_NONE,
                                 condition_code_byte_ff[csfb_pkg::CC_I]};
  logic [31:0] rd_data;
  always_comb
  begin
    case (wb_adr_i)
      csfb_pkg::OFS_PC:   rd_data = {16'h0000, program_counter_ff};
      csfb_pkg::OFS_ACC:  rd_data = {16'h0000, acc_ff};
      csfb_pkg::OFS_TMP:  rd_data = {16'h0000, tmp_ff};
      csfb_pkg::OFS_IX:   rd_data = {16'h0000, index_register_ff};
      csfb_pkg::OFS_EP:   rd_data = {16'h0000, extra_pointer_ff};
      csfb_pkg::OFS_SP:   rd_data = {16'h0000, stack_pointer_ff};
      csfb_pkg::OFS_PSW:  rd_data = {16'h0000, program_status_word_ff};
      csfb_pkg::OFS_BANK: rd_data = {16'h0000, bank_addr};
      csfb_pkg::OFS_STAT: rd_data = stat_word;
      default:            rd_data = 32'h0000_0000;
    endcase
  end

  // bus handshake
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rd_data : 32'h0000_0000;
    end
  end

  // sixteen-bit dedicated registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      program_counter_ff <= csfb_pkg::RST_PC;
      acc_ff             <= 16'h0000;
      tmp_ff             <= 16'h0000;
    end
    else
    begin
      program_counter_ff <= nxt_pc;
      acc_ff             <= nxt_acc;
      tmp_ff             <= nxt_tmp;
    end
  end

  // pointer registers, software loaded
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      index_register_ff <= 16'h0000;
      extra_pointer_ff  <= 16'h0000;
      stack_pointer_ff  <= csfb_pkg::RST_SP;
    end
    else
    begin
      if (wr_ix)
        index_register_ff <= merge16(index_register_ff, wb_dat_i[15:0], lane0, lane1);
      if (wr_ep)
        extra_pointer_ff <= merge16(extra_pointer_ff, wb_dat_i[15:0], lane0, lane1);
      if (wr_sp)
        stack_pointer_ff <= merge16(stack_pointer_ff, wb_dat_i[15:0], lane0, lane1);
    end
  end

  // status word, interrupt take and addresses
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bank_select_pointer_ff <= csfb_pkg::RST_RP;
      condition_code_byte_ff <= csfb_pkg::RST_CCR;
      program_status_word_ff <= {csfb_pkg::RST_RP, csfb_pkg::RST_CCR};
      irq_take_ff            <= 1'b0;
      gpr_addr_ff            <= csfb_pkg::BANK_BASE;
      region_ff              <= csfb_pkg::REG_IO;
    end
    else
    begin
      bank_select_pointer_ff <= nxt_rp;
      condition_code_byte_ff <= nxt_ccr;
      program_status_word_ff <= {nxt_rp, nxt_ccr};
      irq_take_ff            <= irq_ok;
      gpr_addr_ff            <= nxt_gpr;
      region_ff              <= nxt_region;
    end
  end

endmodule // csfb_core

// file: verification/csfb_core_assertions.sv
/*
  checker watching the ports of csfb_core.
  assumes one clock domain and bind by the statement after the module.
*/
`timescale 1ns/1ps
module csfb_core_assertions (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst,
  // bus
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic                   wb_ack_o,
  // sequencer and interrupt
  input wire csfb_pkg::csfb_cmd_t    seq_cmd,
  input wire logic [2:0]             seq_reg_idx,
  input wire logic [15:0]            seq_mem_addr,
  input wire logic                   irq_req,
  input wire logic [1:0]             irq_level,
  input wire logic                   irq_take_ff,
  // state
  input wire logic [15:0]            acc_ff,
  input wire logic [15:0]            program_status_word_ff,
  input wire logic [15:0]            gpr_addr_ff,
  input wire csfb_pkg::csfb_region_t region_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic [15:0] psw    = program_status_word_ff;
  wire logic        cmd_ok = seq_cmd.valid && !(wb_cyc_i && wb_stb_i && wb_we_i);
  function automatic csfb_pkg::csfb_region_t region_of(input logic [15:0] a);
    if (a <= csfb_pkg::IO_LAST) return csfb_pkg::REG_IO;
    if (a <= csfb_pkg::DATA_LAST) return csfb_pkg::REG_DATA;
    if (a >= csfb_pkg::PROG_FIRST) return csfb_pkg::REG_PROG;
    return csfb_pkg::REG_GAP;
  endfunction
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_take;
    irq_req && psw[6] && irq_level < psw[5:4] && !irq_take_ff;
  endsequence
  AST_ACK_PULSE: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one pulse after request");
  AST_IRQ_TAKE: assert property (s_take |=> irq_take_ff && !psw[6] ##1 !irq_take_ff)
    else $error("admitted interrupt not taken");
  AST_IRQ_CAUSE: assert property (irq_take_ff |-> $past(psw[6]) && $past(irq_req))
    else $error("interrupt taken while disabled");
  AST_LEVEL_NONE: assert property (irq_level == 2'h3 |=> !irq_take_ff)
    else $error("lowest level request taken");
  AST_I_RESET: assert property ($past(rst) |-> psw[7:0] == 8'h30)
    else $error("enable flag not cleared by reset");
  AST_BANK_ADDR: assert property (!$past(rst) |-> gpr_addr_ff == csfb_pkg::BANK_BASE
    + {8'h00, $past(psw[12:8]), 3'h0} + {13'h0000, $past(seq_reg_idx)})
    else $error("bank register address wrong");
  AST_REGION: assert property (!$past(rst) |-> region_ff == region_of($past(seq_mem_addr)))
    else $error("address region wrong");
  AST_ZN_FLAGS: assert property (cmd_ok && seq_cmd.op == csfb_pkg::OP_ADD && !seq_cmd.wide
    |=> psw[2] == (acc_ff[7:0] == 8'h00) && psw[3] == acc_ff[7])
    else $error("zero or negative flag wrong");
  AST_HIGH_KEEP: assert property (cmd_ok && !seq_cmd.wide
    && seq_cmd.op inside {[csfb_pkg::OP_ADD:csfb_pkg::OP_SHR]} |=> $stable(acc_ff[15:8]))
    else $error("byte operation changed high byte");
  AST_BANK_LOAD: assert property (cmd_ok && seq_cmd.op == csfb_pkg::OP_LDRP
    |=> psw[15:8] == $past(seq_cmd.data[7:0]))
    else $error("bank pointer not loaded");
endmodule // csfb_core_assertions

bind csfb_core csfb_core_assertions u_chk (
  .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .seq_cmd(seq_cmd), .seq_reg_idx(seq_reg_idx),
  .seq_mem_addr(seq_mem_addr), .irq_req(irq_req), .irq_level(irq_level),
  .irq_take_ff(irq_take_ff), .acc_ff(acc_ff), .program_status_word_ff(program_status_word_ff),
  .gpr_addr_ff(gpr_addr_ff), .region_ff(region_ff));

// file: verification/csfb_seq_model.sv
/*
  instruction sequencer and interrupt source model.
  assumes sys_clk; every change follows a rising edge.
*/
`timescale 1ns/1ps
module csfb_seq_model (
  // clock
  input  wire logic          sys_clk,
  // toward the core
  output csfb_pkg::csfb_cmd_t seq_cmd,
  output logic [2:0]         seq_reg_idx,
  output logic [15:0]        seq_mem_addr,
  output logic               irq_req,
  output logic [1:0]         irq_level
);
  initial
  begin
    seq_cmd = '0;
    seq_reg_idx = 3'h0;
    seq_mem_addr = 16'h0000;
    irq_req = 1'b0;
    irq_level = 2'h3;
  end
  // one command, held for one edge
  task automatic issue(input csfb_pkg::csfb_op_t op, input logic wide, input logic [15:0] d);
    @(posedge sys_clk);
    seq_cmd <= '{valid: 1'b1, op: op, wide: wide, data: d};
    @(posedge sys_clk);
    seq_cmd.valid <= 1'b0;
  endtask
  task automatic request(input logic [1:0] lvl);
    @(posedge sys_clk);
    irq_req <= 1'b1;
    irq_level <= lvl;
    @(posedge sys_clk);
    irq_req <= 1'b0;
    irq_level <= ~lvl;
  endtask
  task automatic point(input logic [2:0] idx, input logic [15:0] a);
    @(posedge sys_clk);
    seq_reg_idx <= idx;
    seq_mem_addr <= a;
    @(posedge sys_clk);
  endtask
endmodule // csfb_seq_model

// file: verification/csfb_core_bench.sv
/*
  self-checking bench of csfb_core.
  assumes csfb_seq_model as sequencer and the bound checker.
*/
`timescale 1ns/1ps
module csfb_core_bench;
  logic                   sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_take_ff;
  logic [7:0]             wb_adr_i;
  logic [31:0]            wb_dat_i, wb_dat_o, rd;
  logic [15:0]            program_counter_ff, acc_ff, program_status_word_ff, gpr_addr_ff;
  csfb_pkg::csfb_region_t region_ff;
  int                     failures, checks_done;
  logic [7:0]             ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [15:0]            adr [7] = '{16'h0000, 16'h007F, 16'h0080, 16'h07FF,
                                      16'h0800, 16'h8000, 16'hFFFF};
  logic [1:0]             rgn [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2};
  csfb_seq_model sq (.sys_clk(sys_clk), .seq_cmd(), .seq_reg_idx(), .seq_mem_addr(),
    .irq_req(), .irq_level());
  csfb_core dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .seq_cmd(sq.seq_cmd),
    .seq_reg_idx(sq.seq_reg_idx), .seq_mem_addr(sq.seq_mem_addr), .irq_req(sq.irq_req),
    .irq_level(sq.irq_level), .irq_take_ff(irq_take_ff),
    .program_counter_ff(program_counter_ff), .acc_ff(acc_ff), .index_register_ff(),
    .extra_pointer_ff(), .stack_pointer_ff(), .program_status_word_ff(program_status_word_ff),
    .gpr_addr_ff(gpr_addr_ff), .region_ff(region_ff));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // look at ack away from the edge that launches it
    @(negedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 20) failures++;
    rd = wb_dat_o;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // byte operation on a and b, then result and flags
  task automatic alu(input csfb_pkg::csfb_op_t op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] r;
    logic       s, h, v;
    sq.issue(csfb_pkg::OP_LDA, 1'b1, {8'hAB, a});
    sq.issue(csfb_pkg::OP_LDT, 1'b1, {8'h5A, b});
    sq.issue(op, 1'b0, 16'h0000);
    @(negedge sys_clk);
    s = op == csfb_pkg::OP_SUB;
    r = s ? a - b : a + b;
    h = s ? a[3:0] < b[3:0] : a[3:0] + b[3:0] > 15;
    v = (a[7] ^ r[7]) & (s ? a[7] ^ b[7] : ~(a[7] ^ b[7]));
    chk(acc_ff, {8'hAB, r[7:0]});
    chk(program_status_word_ff[7], h);
    chk(program_status_word_ff[3:0], {r[7], r[7:0] == 8'h00, v, r[8]});
  endtask
  task automatic irq_try(input logic [1:0] lvl, input logic exp);
    sq.request(lvl);
    @(negedge sys_clk);
    chk(irq_take_ff, exp);
    if (exp) chk(program_status_word_ff[6], 1'b0);
    sq.issue(csfb_pkg::OP_SETI, 1'b0, 16'h0000);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end
  initial
  begin
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(program_status_word_ff, 16'h0030);
    chk(gpr_addr_ff, 16'h0100);
    chk(program_counter_ff, 16'h0000);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    sq.issue(csfb_pkg::OP_LDPC, 1'b1, 16'h1000);
    sq.issue(csfb_pkg::OP_INPC, 1'b1, 16'h0004);
    @(negedge sys_clk);
    chk(program_counter_ff, 16'h1004);
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b1, ofs[i], 32'hFFFF_8421 ^ i);
      wb(1'b0, ofs[i], 32'h0000_0000);
      chk(rd, 32'h0000_8421 ^ i);
    end
    wb(1'b1, 8'h40, 32'h0000_1234);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test registers done");
    alu(csfb_pkg::OP_ADD, 8'h08, 8'h08);
    alu(csfb_pkg::OP_ADD, 8'h7F, 8'h01);
    alu(csfb_pkg::OP_ADD, 8'hFF, 8'h01);
    alu(csfb_pkg::OP_SUB, 8'h10, 8'h01);
    alu(csfb_pkg::OP_SUB, 8'h00, 8'h01);
    alu(csfb_pkg::OP_SUB, 8'h80, 8'h01);
    sq.issue(csfb_pkg::OP_LDA, 1'b1, 16'h3C81);
    sq.issue(csfb_pkg::OP_SHL, 1'b0, 16'h0000);
    @(negedge sys_clk);
    chk(acc_ff, 16'h3C02);
    chk(program_status_word_ff[0], 1'b1);
    $display("test flags done");
    wb(1'b1, 8'h18, 32'h0000_0A30);
    chk(program_status_word_ff, 16'h0A30);
    sq.point(3'h3, 16'h0000);
    @(negedge sys_clk);
    chk(gpr_addr_ff, 16'h0153);
    wb(1'b1, 8'h1C, 32'h0000_FFFF);
    wb(1'b0, 8'h1C, 32'h0000_0000);
    chk(rd, 32'h0000_0150);
    sq.issue(csfb_pkg::OP_LDRP, 1'b0, 16'h001F);
    for (int i = 0; i < 7; i++)
    begin
      sq.point(3'h7, adr[i]);
      @(negedge sys_clk);
      chk(region_ff, rgn[i]);
      chk(gpr_addr_ff, 16'h01FF);
    end
    $display("test banks done");
    sq.issue(csfb_pkg::OP_LDIL, 1'b0, 16'h0001);
    sq.issue(csfb_pkg::OP_SETI, 1'b0, 16'h0000);
    irq_try(2'h0, 1'b1);
    irq_try(2'h1, 1'b0);
    sq.issue(csfb_pkg::OP_LDIL, 1'b0, 16'h0003);
    irq_try(2'h3, 1'b0);
    irq_try(2'h2, 1'b1);
    sq.issue(csfb_pkg::OP_CLRI, 1'b0, 16'h0000);
    irq_try(2'h0, 1'b0);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(program_status_word_ff, 16'h0030);
    $display("test interrupts done");
    give_verdict();
  end
endmodule // csfb_core_bench
